// file: sbp_pkg.sv
// Package of constants for the sector block protection logic
package sbp_pkg;
  // Geometry: 256 KB blocks of 4 KB sectors
  localparam int ADDR_W = 25;
  localparam int BLOCK_SHIFT = 18;
  localparam int NUM_BLOCKS = 128;
  localparam int BLK_W = 7;
  localparam int SECTOR_KB = 4;
  localparam int SECTORS_PER_BLOCK = 64;
  // Bit values
  localparam logic BIT_PROTECT = 1'h0;
  localparam logic BIT_OPEN = 1'h1;
  // Timing, nominal microseconds and nanoseconds
  localparam int CLK_MHZ = 100;
  localparam int PAGE_PROG_US = 200;
  localparam int SECTOR_ERASE_US = 45000;
  localparam int PROG_CYCLES = PAGE_PROG_US * CLK_MHZ;
  localparam int ERASE_CYCLES = SECTOR_ERASE_US * CLK_MHZ;
  localparam int INIT_ACCESS_NS = 50;
  localparam int READ_CYCLES = (INIT_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 23;
  // Avalon register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0C;
  // Command codes written to REG_CTRL[3:0]
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_PERS_PROG = 4'h1;
  localparam logic [3:0] CMD_PERS_ERASE = 4'h2;
  localparam logic [3:0] CMD_PERS_READ = 4'h3;
  localparam logic [3:0] CMD_DYN_WRITE = 4'h4;
  localparam logic [3:0] CMD_DYN_READ = 4'h5;
  localparam logic [3:0] CMD_LOCK_CLEAR = 4'h6;
  localparam logic [3:0] CMD_UNLOCK_OK = 4'h7;
  localparam logic [3:0] CMD_SOFT_RESET = 4'h8;
  localparam int CTRL_DYN_VAL_BIT = 4;
  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_FAIL = 1;
  localparam int ST_LOCK = 2;
  localparam int ST_RD_BLOCK = 3;
  localparam int ST_PWD_MODE = 4;
  localparam int ST_PROTECTED = 5;
  typedef enum logic [3:0] {
    SBP_IDLE  = 4'h1,
    SBP_PROG  = 4'h2,
    SBP_ERASE = 4'h4,
    SBP_READ  = 4'h8
  } sbp_state_e;
endpackage

// file: sbp_block_map.sv
// Address to protection block mapping and protection decision
`timescale 1ns/1ps
`default_nettype none
module sbp_block_map #(
  parameter int AW = sbp_pkg::ADDR_W,
  parameter int BW = sbp_pkg::BLK_W,
  parameter int NB = sbp_pkg::NUM_BLOCKS
) (
  // Query
  input wire logic [AW-1:0] addr,
  input wire logic [NB-1:0] pers_bits,
  input wire logic [NB-1:0] dyn_bits,
  // Result
  output logic [BW-1:0] block_idx,
  output logic is_protected
);
  // One group per 256 KB block; top/bottom selection unused here
  assign block_idx = addr[sbp_pkg::BLOCK_SHIFT +: BW];
  // Either bit at zero protects the block
  assign is_protected = (pers_bits[block_idx] == sbp_pkg::BIT_PROTECT)
    || (dyn_bits[block_idx] == sbp_pkg::BIT_PROTECT);
endmodule
`default_nettype wire

// file: sbp_protect.sv
// Advanced sector block protection engine with Avalon-MM registers
//
// Overview of operation
// - One persistent, one dynamic bit per 256KB block
// - Persistent bits program singly, erase together
// - Erase preprogram and verify done internally
// - Program page time, erase sector time
// - Busy flag readable during program or erase
// - Program drives zero, erase sets all one
// - Lock zero fails program and erase
// - No array reads while programming persistent bit
// - Erase takes no address, no single erase
// - Persistent bit read with initial access latency
// - Fresh persistent bits are all one
// - Dynamic write sets zero protect, one open
// - Protected when either bit is zero
// - Dynamic writes unlimited and never locked
// - Single volatile lock guards persistent bits
// - Persistent mode: lock one at reset, sticky clear
// - Password mode: lock zero, unlock sets one
// - Soft reset keeps lock; clear command only
// - Resets return dynamic bits to open
`timescale 1ns/1ps
`default_nettype none
module sbp_protect #(
  parameter int NB = sbp_pkg::NUM_BLOCKS,
  parameter int PROG_CYC = sbp_pkg::PROG_CYCLES,
  parameter int ERASE_CYC = sbp_pkg::ERASE_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Mode strap: high selects password protection
  input wire logic password_mode,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Main array access check
  input wire logic [sbp_pkg::ADDR_W-1:0] array_addr,
  input wire logic array_write_req,
  output logic array_write_ok,
  output logic array_read_ok
);
  localparam int AW = sbp_pkg::ADDR_W;
  localparam int BW = sbp_pkg::BLK_W;
  localparam int CW = sbp_pkg::CNT_W;

  typedef struct packed {
    sbp_pkg::sbp_state_e state;
    logic [NB-1:0] pers;
    logic [NB-1:0] dyn;
    logic lock;
    logic fail;
    logic [CW-1:0] cnt;
    logic [AW-1:0] addr;
    logic result;
    logic [31:0] rdata;
    logic ack;
    logic strap_seen;
  } sbp_state_s;

  sbp_state_s s_q;
  sbp_state_s s_d;

  logic [BW-1:0] cmd_blk;
  logic cmd_prot;
  logic [BW-1:0] arr_blk;
  logic arr_prot;
  logic access;
  logic wr_ctrl;
  logic [3:0] cmd;
  logic busy;

  sbp_block_map u_cmd_map (
    .addr(s_q.addr),
    .pers_bits(s_q.pers),
    .dyn_bits(s_q.dyn),
    .block_idx(cmd_blk),
    .is_protected(cmd_prot)
  );

  sbp_block_map u_arr_map (
    .addr(array_addr),
    .pers_bits(s_q.pers),
    .dyn_bits(s_q.dyn),
    .block_idx(arr_blk),
    .is_protected(arr_prot)
  );

  assign busy = (s_q.state != sbp_pkg::SBP_IDLE);
  assign access = (avs_read || avs_write) && !s_q.ack;
  assign wr_ctrl = avs_write && !s_q.ack && (avs_address == sbp_pkg::REG_CTRL)
    && avs_byteenable[0];
  assign cmd = avs_writedata[3:0];
  // One wait cycle per access; answer on the following edge
  assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
  assign avs_readdata = s_q.rdata;
  // Rejected when protected or engine busy
  assign array_write_ok = array_write_req && !arr_prot && !busy;
  assign array_read_ok = (s_q.state != sbp_pkg::SBP_PROG);

  always_comb
  begin
    s_d = s_q;
    s_d.ack = access;
    // Strap sampled on first clock after reset release
    if (!s_q.strap_seen)
    begin
      s_d.strap_seen = 1'h1;
      s_d.lock = password_mode ? 1'h0 : 1'h1;
    end
    case (s_q.state)
      sbp_pkg::SBP_IDLE:
      begin
        if (wr_ctrl)
        begin
          case (cmd)
            sbp_pkg::CMD_PERS_PROG:
            begin
              s_d.fail = 1'h0;
              if (!s_q.lock)
                s_d.fail = 1'h1;
              else
              begin
                s_d.state = sbp_pkg::SBP_PROG;
                s_d.cnt = CW'(PROG_CYC - 1);
              end
            end
            sbp_pkg::CMD_PERS_ERASE:
            begin
              // Address register is ignored for erase
              s_d.fail = 1'h0;
              if (!s_q.lock)
                s_d.fail = 1'h1;
              else
              begin
                s_d.state = sbp_pkg::SBP_ERASE;
                s_d.cnt = CW'(ERASE_CYC - 1);
              end
            end
            sbp_pkg::CMD_PERS_READ, sbp_pkg::CMD_DYN_READ:
            begin
              s_d.result = (cmd == sbp_pkg::CMD_PERS_READ) ? s_q.pers[cmd_blk]
                : s_q.dyn[cmd_blk];
              s_d.state = sbp_pkg::SBP_READ;
              s_d.cnt = CW'(sbp_pkg::READ_CYCLES - 1);
            end
            sbp_pkg::CMD_DYN_WRITE:
              // Accepted whenever idle, no lock involved
              s_d.dyn[cmd_blk] = avs_writedata[sbp_pkg::CTRL_DYN_VAL_BIT];
            sbp_pkg::CMD_LOCK_CLEAR:
              s_d.lock = 1'h0;
            sbp_pkg::CMD_UNLOCK_OK:
              if (password_mode)
                s_d.lock = 1'h1;
            sbp_pkg::CMD_SOFT_RESET:
              // Lock survives a soft reset
              s_d.dyn = {NB{sbp_pkg::BIT_OPEN}};
            default:
              s_d.state = s_q.state;
          endcase
        end
      end
      sbp_pkg::SBP_PROG:
      begin
        if (s_q.cnt == '0)
        begin
          s_d.pers[cmd_blk] = sbp_pkg::BIT_PROTECT;
          s_d.state = sbp_pkg::SBP_IDLE;
        end
        else
          s_d.cnt = s_q.cnt - CW'(1);
      end
      sbp_pkg::SBP_ERASE:
      begin
        // Preprogram and verify folded into the timed erase
        if (s_q.cnt == '0)
        begin
          s_d.pers = {NB{sbp_pkg::BIT_OPEN}};
          s_d.state = sbp_pkg::SBP_IDLE;
        end
        else
          s_d.cnt = s_q.cnt - CW'(1);
      end
      sbp_pkg::SBP_READ:
      begin
        if (s_q.cnt == '0)
          s_d.state = sbp_pkg::SBP_IDLE;
        else
          s_d.cnt = s_q.cnt - CW'(1);
      end
      default:
        s_d.state = sbp_pkg::SBP_IDLE;
    endcase
    // Address register; high unused bits expected zero from host
    if (avs_write && !s_q.ack && avs_address == sbp_pkg::REG_ADDR && !busy)
      s_d.addr = avs_writedata[AW-1:0];
    s_d.rdata = 32'h0;
    if (avs_read && !s_q.ack)
    begin
      case (avs_address)
        sbp_pkg::REG_ADDR:
          s_d.rdata = {{(32-AW){1'b0}}, s_q.addr};
        sbp_pkg::REG_STATUS:
        begin
          s_d.rdata[sbp_pkg::ST_BUSY] = busy && s_q.state != sbp_pkg::SBP_READ;
          s_d.rdata[sbp_pkg::ST_FAIL] = s_q.fail;
          s_d.rdata[sbp_pkg::ST_LOCK] = s_q.lock;
          s_d.rdata[sbp_pkg::ST_RD_BLOCK] = !array_read_ok;
          s_d.rdata[sbp_pkg::ST_PWD_MODE] = password_mode;
          s_d.rdata[sbp_pkg::ST_PROTECTED] = cmd_prot;
        end
        sbp_pkg::REG_RESULT:
          s_d.rdata[0] = s_q.result;
        default:
          s_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q.state <= sbp_pkg::SBP_IDLE;
      // Persistent bits modelled in flops, reset to factory state
      s_q.pers <= {NB{sbp_pkg::BIT_OPEN}};
      s_q.dyn <= {NB{sbp_pkg::BIT_OPEN}};
      s_q.lock <= 1'h0;
      s_q.fail <= 1'h0;
      s_q.cnt <= '0;
      s_q.addr <= '0;
      s_q.result <= 1'h0;
      s_q.rdata <= 32'h0;
      s_q.ack <= 1'h0;
      s_q.strap_seen <= 1'h0;
    end
    else
      s_q <= s_d;
  end

  a_lock_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.strap_seen && !password_mode && !s_q.lock) |=> !s_q.lock)
    else $error("lock set again in persistent mode");
  a_lock_fail: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_ctrl && !busy && !s_q.lock && s_q.strap_seen
     && (cmd == sbp_pkg::CMD_PERS_PROG || cmd == sbp_pkg::CMD_PERS_ERASE))
    |=> (s_q.fail && !busy && $stable(s_q.pers)))
    else $error("locked persistent command executed");
  a_prog_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.state == sbp_pkg::SBP_PROG && s_q.cnt == '0)
    |=> (s_q.pers[cmd_blk] == 1'b0 && !busy))
    else $error("program did not clear bit");
  a_erase_all: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.state == sbp_pkg::SBP_ERASE && s_q.cnt == '0) |=> (&s_q.pers))
    else $error("erase did not set all bits");
  a_read_block: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.state == sbp_pkg::SBP_PROG) |-> !array_read_ok)
    else $error("array read during program");
  a_write_reject: assert property (@(posedge sys_clk) disable iff (rst)
    (array_write_req && (!s_q.pers[arr_blk] || !s_q.dyn[arr_blk])) |-> !array_write_ok)
    else $error("protected block write allowed");
  a_soft_keep: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_ctrl && !busy && cmd == sbp_pkg::CMD_SOFT_RESET && s_q.strap_seen)
    |=> ($stable(s_q.lock) && (&s_q.dyn)))
    else $error("soft reset misbehaved");
  a_dyn_write: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_ctrl && !busy && cmd == sbp_pkg::CMD_DYN_WRITE)
    |=> (s_q.dyn[cmd_blk] == $past(avs_writedata[sbp_pkg::CTRL_DYN_VAL_BIT])))
    else $error("dynamic write lost");
  a_prog_len: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(s_q.state == sbp_pkg::SBP_PROG) |-> (s_q.cnt == CW'(PROG_CYC - 1)))
    else $error("program time wrong");
  a_erase_len: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(s_q.state == sbp_pkg::SBP_ERASE) |-> (s_q.cnt == CW'(ERASE_CYC - 1)))
    else $error("erase time wrong");
  a_clear_only: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.strap_seen && s_q.lock
     && !(wr_ctrl && !busy && cmd == sbp_pkg::CMD_LOCK_CLEAR)) |=> s_q.lock)
    else $error("lock cleared without clear command");
  a_pwd_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.strap_seen && password_mode && !s_q.lock
     && !(wr_ctrl && !busy && cmd == sbp_pkg::CMD_UNLOCK_OK)) |=> !s_q.lock)
    else $error("lock set without unlock in password mode");
endmodule
`default_nettype wire

// file: sbp_host_model.sv
// Avalon-MM host model issuing protection commands
`timescale 1ns/1ps
`default_nettype none
module sbp_host_model (
  // Clock
  input wire logic sys_clk,
  // Slave answer
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  // Request
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata
);
  initial
  begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  // Released lines show inverted data, never a stale match
  task automatic bus_cycle(input logic [7:0] a, input logic wr, input logic [31:0] d,
                           output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench of the sector block protection logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk, rst, password_mode, array_write_req, avs_read, avs_write, avs_waitrequest;
  logic array_write_ok, array_read_ok;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, s;
  logic [24:0] array_addr;
  int error_cnt = 0;
  int total_checks = 0;
  sbp_protect #(.PROG_CYC(20), .ERASE_CYC(40)) u_sbp_protect (.sys_clk(sys_clk), .rst(rst),
    .password_mode(password_mode), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .array_addr(array_addr),
    .array_write_req(array_write_req), .array_write_ok(array_write_ok),
    .array_read_ok(array_read_ok));
  sbp_host_model u_sbp_host_model (.sys_clk(sys_clk), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic hw_reset(input logic pm);
    password_mode <= pm;
    rst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_sbp_host_model.bus_cycle(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    u_sbp_host_model.bus_cycle(a, 1'b0, 32'h0, q);
  endtask
  // Block base address with unused high bits zero
  task automatic cmd(input int blk, input logic [31:0] c);
    wr(sbp_pkg::REG_ADDR, 32'(blk) << sbp_pkg::BLOCK_SHIFT);
    wr(sbp_pkg::REG_CTRL, c);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      rd(sbp_pkg::REG_STATUS, s);
      n++;
    end
    while (s[sbp_pkg::ST_BUSY] !== 1'b0 && n < 100);
    chk("busy", s[sbp_pkg::ST_BUSY], 1'b0);
  endtask
  task automatic bit_rd(input int blk, input logic [3:0] c, output logic [31:0] q);
    cmd(blk, c);
    repeat (sbp_pkg::READ_CYCLES + 2) @(posedge sys_clk);
    rd(sbp_pkg::REG_RESULT, q);
  endtask
  // Array request changes only on a rising edge, checked once settled
  task automatic wr_ok(input int blk, input logic exp);
    @(posedge sys_clk);
    array_addr <= 25'(blk) << sbp_pkg::BLOCK_SHIFT;
    array_write_req <= 1'b1;
    @(negedge sys_clk);
    chk("write_ok", array_write_ok, exp);
  endtask
  initial
  begin
    array_addr = 25'h0;
    array_write_req = 1'b0;
    hw_reset(1'b0);
    rd(sbp_pkg::REG_STATUS, s);
    chk("lock", s[sbp_pkg::ST_LOCK], 1'b1);
    chk("fail", s[sbp_pkg::ST_FAIL], 1'b0);
    bit_rd(5, sbp_pkg::CMD_PERS_READ, s);
    chk("pers", s[0], 1'b1);
    rd(8'h10, s);
    chk("unmapped", s, 32'h0);
    wr_ok(5, 1'b1);
    $display("test reset done");
    // Repeated protect/open cycles, never locked out
    repeat (2)
    begin
      cmd(5, 32'h04);
      wr_ok(5, 1'b0);
      wr_ok(6, 1'b1);
      rd(sbp_pkg::REG_STATUS, s);
      chk("protected", s[sbp_pkg::ST_PROTECTED], 1'b1);
      bit_rd(5, sbp_pkg::CMD_DYN_READ, s);
      chk("dyn", s[0], 1'b0);
      cmd(5, 32'h14);
      wr_ok(5, 1'b1);
    end
    $display("test dynamic done");
    cmd(5, sbp_pkg::CMD_PERS_PROG);
    @(negedge sys_clk);
    chk("read_ok", array_read_ok, 1'b0);
    rd(sbp_pkg::REG_STATUS, s);
    chk("busy set", s[sbp_pkg::ST_BUSY], 1'b1);
    chk("read blocked", s[sbp_pkg::ST_RD_BLOCK], 1'b1);
    // Open block still refused while the engine is busy
    wr_ok(6, 1'b0);
    wait_idle();
    chk("read_ok", array_read_ok, 1'b1);
    bit_rd(5, sbp_pkg::CMD_PERS_READ, s);
    chk("pers prog", s[0], 1'b0);
    bit_rd(6, sbp_pkg::CMD_PERS_READ, s);
    chk("pers other", s[0], 1'b1);
    wr_ok(5, 1'b0);
    $display("test program done");
    wr(sbp_pkg::REG_CTRL, sbp_pkg::CMD_PERS_ERASE);
    wait_idle();
    bit_rd(5, sbp_pkg::CMD_PERS_READ, s);
    chk("pers erase", s[0], 1'b1);
    cmd(7, 32'h04);
    rd(sbp_pkg::REG_STATUS, s);
    chk("protected 7", s[sbp_pkg::ST_PROTECTED], 1'b1);
    wr(sbp_pkg::REG_CTRL, sbp_pkg::CMD_SOFT_RESET);
    bit_rd(7, sbp_pkg::CMD_DYN_READ, s);
    chk("dyn soft", s[0], 1'b1);
    rd(sbp_pkg::REG_STATUS, s);
    chk("lock soft", s[sbp_pkg::ST_LOCK], 1'b1);
    $display("test erase done");
    // Final persistent state is in place before locking
    wr(sbp_pkg::REG_CTRL, sbp_pkg::CMD_LOCK_CLEAR);
    cmd(5, sbp_pkg::CMD_PERS_PROG);
    wait_idle();
    chk("lock clr", s[sbp_pkg::ST_LOCK], 1'b0);
    chk("fail", s[sbp_pkg::ST_FAIL], 1'b1);
    bit_rd(5, sbp_pkg::CMD_PERS_READ, s);
    chk("pers locked", s[0], 1'b1);
    wr(sbp_pkg::REG_CTRL, sbp_pkg::CMD_UNLOCK_OK);
    wr(sbp_pkg::REG_CTRL, sbp_pkg::CMD_SOFT_RESET);
    rd(sbp_pkg::REG_STATUS, s);
    chk("lock sticky", s[sbp_pkg::ST_LOCK], 1'b0);
    $display("test lock done");
    hw_reset(1'b1);
    rd(sbp_pkg::REG_STATUS, s);
    chk("lock pwd", s[sbp_pkg::ST_LOCK], 1'b0);
    chk("pwd mode", s[sbp_pkg::ST_PWD_MODE], 1'b1);
    wr(sbp_pkg::REG_CTRL, sbp_pkg::CMD_UNLOCK_OK);
    rd(sbp_pkg::REG_STATUS, s);
    chk("lock unl", s[sbp_pkg::ST_LOCK], 1'b1);
    $display("test password done");
    results();
  end
  // Whole sequence needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
